/* File: dpsm_top.sv */
`timescale 1ns/10ps
module dpsm_top (
  input  wire logic        core_clk,
  input  wire logic        reset,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic [1:0]  pin_i,
  output logic [1:0]       pin_o,
  output logic [1:0]       pin_oe
);

  // ==========================================================================
  // Register state
  // ==========================================================================
  logic [7:0]          ctrl_r, ctrl_nxt;
  logic [7:0]          duty0_r, duty0_nxt;
  logic [7:0]          duty1_r, duty1_nxt;
  dpsm_pkg::dpsm_port_t port_r, port_nxt;
  logic [7:0]          cnt_r, cnt_nxt;
  logic                aw_got_r, aw_got_nxt;
  logic                w_got_r, w_got_nxt;
  logic [7:0]          awaddr_r, awaddr_nxt;
  logic [31:0]         wdata_r, wdata_nxt;
  logic                wlane_r, wlane_nxt;
  logic                awready_r, awready_nxt;
  logic                wready_r, wready_nxt;
  logic                bvalid_r, bvalid_nxt;
  logic [1:0]          bresp_r, bresp_nxt;
  logic                arready_r, arready_nxt;
  logic                rvalid_r, rvalid_nxt;
  logic [31:0]         rdata_r, rdata_nxt;
  logic [1:0]          rresp_r, rresp_nxt;
  logic                do_write;
  logic [7:0]          wb;
  logic                split_four;
  logic [1:0]          wave;
  logic [1:0]          sel;

  // ==========================================================================
  // Cycle counter
  // ==========================================================================
  always_comb begin
    cnt_nxt = cnt_r + 8'h01;  // Free-running, wraps each 256 clocks
  end

  // ==========================================================================
  // AXI4-Lite write
  // ==========================================================================
  always_comb begin
    aw_got_nxt  = aw_got_r;
    w_got_nxt   = w_got_r;
    awaddr_nxt  = awaddr_r;
    wdata_nxt   = wdata_r;
    wlane_nxt   = wlane_r;
    bvalid_nxt  = bvalid_r;
    bresp_nxt   = bresp_r;
    ctrl_nxt    = ctrl_r;
    duty0_nxt   = duty0_r;
    duty1_nxt   = duty1_r;
    port_nxt    = port_r;
    awready_nxt = !aw_got_r && !bvalid_r && !(s_axi_awvalid && awready_r);
    wready_nxt  = !w_got_r && !bvalid_r && !(s_axi_wvalid && wready_r);
    if (s_axi_awvalid && awready_r) begin
      aw_got_nxt = 1'b1;
      awaddr_nxt = s_axi_awaddr;
    end
    if (s_axi_wvalid && wready_r) begin
      w_got_nxt = 1'b1;
      wdata_nxt = s_axi_wdata;
      wlane_nxt = s_axi_wstrb[0];
    end
    do_write = aw_got_r && w_got_r;
    wb       = wdata_r[7:0];
    if (do_write) begin
      aw_got_nxt = 1'b0;
      w_got_nxt  = 1'b0;
      bvalid_nxt = 1'b1;
      bresp_nxt  = dpsm_pkg::RESP_OKAY;
      case (awaddr_r)
        dpsm_pkg::ADDR_CONTROL: begin
          if (wlane_r) begin
            ctrl_nxt = wb;
          end
        end
        dpsm_pkg::ADDR_DUTY0: begin
          if (wlane_r) begin
            duty0_nxt = wb;
          end
        end
        dpsm_pkg::ADDR_DUTY1: begin
          if (wlane_r) begin
            duty1_nxt = wb;
          end
        end
        dpsm_pkg::ADDR_PORT_DIR: begin
          if (wlane_r) begin
            port_nxt.dir = wb[1:0];
          end
        end
        dpsm_pkg::ADDR_PORT_OUT: begin
          if (wlane_r) begin
            port_nxt.out = wb[1:0];
          end
        end
        dpsm_pkg::ADDR_STATUS: begin
        end
        default: begin
          bresp_nxt = dpsm_pkg::RESP_SLVERR;
        end
      endcase
    end else if (bvalid_r && s_axi_bready) begin
      bvalid_nxt = 1'b0;
    end
  end

  // ==========================================================================
  // AXI4-Lite read
  // ==========================================================================
  always_comb begin
    arready_nxt = !rvalid_r && !(s_axi_arvalid && arready_r);
    rvalid_nxt  = rvalid_r;
    rdata_nxt   = rdata_r;
    rresp_nxt   = rresp_r;
    if (s_axi_arvalid && arready_r) begin
      rvalid_nxt = 1'b1;
      rresp_nxt  = dpsm_pkg::RESP_OKAY;
      case (s_axi_araddr)
        dpsm_pkg::ADDR_CONTROL:  rdata_nxt = {24'h000000, ctrl_r};
        dpsm_pkg::ADDR_DUTY0:    rdata_nxt = {24'h000000, duty0_r};
        dpsm_pkg::ADDR_DUTY1:    rdata_nxt = {24'h000000, duty1_r};
        dpsm_pkg::ADDR_PORT_DIR: rdata_nxt = {30'h0, port_r.dir};
        dpsm_pkg::ADDR_PORT_OUT: rdata_nxt = {30'h0, port_r.out};
        dpsm_pkg::ADDR_STATUS:   rdata_nxt = {20'h00000, pin_i, wave, cnt_r};
        default: begin
          rdata_nxt = 32'h00000000;
          rresp_nxt = dpsm_pkg::RESP_SLVERR;
        end
      endcase
    end else if (rvalid_r && s_axi_rready) begin
      rvalid_nxt = 1'b0;
    end
  end

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      ctrl_r    <= dpsm_pkg::CTRL_RESET;
      duty0_r   <= dpsm_pkg::DUTY_RESET;
      duty1_r   <= dpsm_pkg::DUTY_RESET;
      port_r    <= '{dir: dpsm_pkg::PDIR_RESET, out: dpsm_pkg::POUT_RESET};
      cnt_r     <= 8'h00;
      aw_got_r  <= 1'b0;
      w_got_r   <= 1'b0;
      awaddr_r  <= 8'h00;
      wdata_r   <= 32'h00000000;
      wlane_r   <= 1'b0;
      awready_r <= 1'b0;
      wready_r  <= 1'b0;
      bvalid_r  <= 1'b0;
      bresp_r   <= dpsm_pkg::RESP_OKAY;
      arready_r <= 1'b0;
      rvalid_r  <= 1'b0;
      rdata_r   <= 32'h00000000;
      rresp_r   <= dpsm_pkg::RESP_OKAY;
    end else begin
      ctrl_r    <= ctrl_nxt;
      duty0_r   <= duty0_nxt;
      duty1_r   <= duty1_nxt;
      port_r    <= port_nxt;
      cnt_r     <= cnt_nxt;
      aw_got_r  <= aw_got_nxt;
      w_got_r   <= w_got_nxt;
      awaddr_r  <= awaddr_nxt;
      wdata_r   <= wdata_nxt;
      wlane_r   <= wlane_nxt;
      awready_r <= awready_nxt;
      wready_r  <= wready_nxt;
      bvalid_r  <= bvalid_nxt;
      bresp_r   <= bresp_nxt;
      arready_r <= arready_nxt;
      rvalid_r  <= rvalid_nxt;
      rdata_r   <= rdata_nxt;
      rresp_r   <= rresp_nxt;
    end
  end

  assign s_axi_awready = awready_r;
  assign s_axi_wready  = wready_r;
  assign s_axi_bvalid  = bvalid_r;
  assign s_axi_bresp   = bresp_r;
  assign s_axi_arready = arready_r;
  assign s_axi_rvalid  = rvalid_r;
  assign s_axi_rdata   = rdata_r;
  assign s_axi_rresp   = rresp_r;

  // ==========================================================================
  // Channels and pins
  // ==========================================================================
  // Split choice is shared by both channels
  assign split_four = (ctrl_r[dpsm_pkg::CTRL_SPLIT_BIT] == dpsm_pkg::DPSM_SPLIT_FOUR);
  assign sel        = {ctrl_r[dpsm_pkg::CTRL_CH1_BIT], ctrl_r[dpsm_pkg::CTRL_CH0_BIT]};

  dpsm_channel u_ch0 (
    .core_clk   (core_clk),
    .reset      (reset),
    .duty       (duty0_r),
    .cnt        (cnt_r),
    .split_four (split_four),
    .wave       (wave[0])
  );

  dpsm_channel u_ch1 (
    .core_clk   (core_clk),
    .reset      (reset),
    .duty       (duty1_r),
    .cnt        (cnt_r),
    .split_four (split_four),
    .wave       (wave[1])
  );

  // Software must clear the direction bit for a PWM pin; otherwise it stays input
  dpsm_pin u_pin0 (
    .core_clk (core_clk),
    .reset    (reset),
    .wave     (wave[0]),
    .sel      (sel[0]),
    .dir_in   (port_r.dir[0]),
    .latch    (port_r.out[0]),
    .pin_o    (pin_o[0]),
    .pin_oe   (pin_oe[0])
  );

  dpsm_pin u_pin1 (
    .core_clk (core_clk),
    .reset    (reset),
    .wave     (wave[1]),
    .sel      (sel[1]),
    .dir_in   (port_r.dir[1]),
    .latch    (port_r.out[1]),
    .pin_o    (pin_o[1]),
    .pin_oe   (pin_oe[1])
  );

  // ==========================================================================
  // Checks
  // ==========================================================================
  a_count_wraps: assert property (@(posedge core_clk) disable iff (reset)
    (cnt_r == dpsm_pkg::CNT_LAST) |=> (cnt_r == 8'h00))
    else $error("counter did not wrap");
  a_input_no_drive: assert property (@(posedge core_clk) disable iff (reset)
    port_r.dir[0] |=> !pin_oe[0])
    else $error("input pin driven");
  a_latch_forces_low: assert property (@(posedge core_clk) disable iff (reset)
    (sel[0] && !port_r.out[0]) |=> !pin_o[0])
    else $error("pin not forced low");
  a_pwm_passes_wave: assert property (@(posedge core_clk) disable iff (reset)
    (sel[1] && port_r.out[1]) |=> (pin_o[1] == $past(wave[1])))
    else $error("wave not passed");
  a_zero_duty_low: assert property (@(posedge core_clk) disable iff (reset)
    (u_ch0.duty_r == 8'h00) |=> !wave[0])
    else $error("zero duty gave high");
  a_sub_start_high: assert property (@(posedge core_clk) disable iff (reset)
    (split_four && cnt_r[5:0] == 6'h00 && u_ch0.duty_r[7:2] != 6'h00 && $stable(split_four))
      |=> wave[0])
    else $error("sub-cycle not starting high");
  a_duty_holds_cycle: assert property (@(posedge core_clk) disable iff (reset)
    (cnt_r != dpsm_pkg::CNT_LAST) |=> $stable(u_ch0.duty_r))
    else $error("duty changed mid cycle");
  // Duty 1 in two-way mode: the single fine clock belongs to sub-cycle 0 only
  sequence s_one_clock_pulse;
    wave[0] ##1 !wave[0];
  endsequence
  a_two_way_fine: assert property (@(posedge core_clk) disable iff (reset)
    (!split_four && cnt_r == 8'h00 && u_ch0.duty_r == 8'h01) |=> s_one_clock_pulse)
    else $error("fine bit misplaced");
  a_two_way_second: assert property (@(posedge core_clk) disable iff (reset)
    (!split_four && cnt_r == 8'h80 && u_ch0.duty_r == 8'h01) |=> !wave[0])
    else $error("second sub-cycle got fine bit");

endmodule : dpsm_top

/* File: dpsm_pkg.sv */
package dpsm_pkg;

  // ==========================================================================
  // Register map (byte addresses, one aligned word each)
  // ==========================================================================
  localparam logic [7:0] ADDR_CONTROL  = 8'h00;
  localparam logic [7:0] ADDR_DUTY0    = 8'h04;
  localparam logic [7:0] ADDR_DUTY1    = 8'h08;
  localparam logic [7:0] ADDR_PORT_DIR = 8'h0c;
  localparam logic [7:0] ADDR_PORT_OUT = 8'h10;
  localparam logic [7:0] ADDR_STATUS   = 8'h14;

  // ==========================================================================
  // Field positions and reset values
  // ==========================================================================
  localparam int         CTRL_SPLIT_BIT = 7;
  localparam int         CTRL_CH1_BIT   = 6;
  localparam int         CTRL_CH0_BIT   = 5;
  localparam logic [7:0] CTRL_RESET     = 8'h00;
  localparam logic [7:0] DUTY_RESET     = 8'h00;
  localparam logic [1:0] PDIR_RESET     = 2'h3;
  localparam logic [1:0] POUT_RESET     = 2'h0;
  localparam logic [1:0] RESP_OKAY      = 2'h0;
  localparam logic [1:0] RESP_SLVERR    = 2'h2;

  // ==========================================================================
  // Timing
  // ==========================================================================
  localparam int         CYCLE_CLOCKS   = 256;
  localparam logic [7:0] CNT_LAST       = 8'hff;

  typedef enum logic {
    DPSM_SPLIT_TWO,
    DPSM_SPLIT_FOUR
  } dpsm_split_t;

  typedef struct packed {
    logic [1:0] dir;
    logic [1:0] out;
  } dpsm_port_t;

endpackage : dpsm_pkg

/* File: dpsm_channel.sv */
`timescale 1ns/10ps
module dpsm_channel (
  input  wire logic       core_clk,
  input  wire logic       reset,
  input  wire logic [7:0] duty,
  input  wire logic [7:0] cnt,
  input  wire logic       split_four,
  output logic            wave
);

  logic       wave_r;
  logic       wave_nxt;
  logic [7:0] duty_r;
  logic [7:0] duty_nxt;
  logic [6:0] coarse;
  logic [6:0] pos;
  logic [1:0] fine;
  logic [1:0] sub;
  logic [7:0] high_cnt;

  // ==========================================================================
  // Duty latch and compare
  // ==========================================================================
  always_comb begin
    duty_nxt = duty_r;
    // Latch at last clock so a whole cycle uses one value
    if (cnt == dpsm_pkg::CNT_LAST) begin
      duty_nxt = duty;
    end
    if (split_four) begin
      coarse = {1'b0, duty_r[7:2]};
      fine   = duty_r[1:0];
      sub    = cnt[7:6];
      pos    = {1'b0, cnt[5:0]};
    end else begin
      coarse = duty_r[7:1];
      fine   = {1'b0, duty_r[0]};
      sub    = {1'b0, cnt[7]};
      pos    = cnt[6:0];
    end
    // Extra clock in early sub-cycles
    high_cnt = {1'b0, coarse} + ((sub < fine) ? 8'h01 : 8'h00);
    // High from first clock of sub-cycle
    wave_nxt = ({1'b0, pos} < high_cnt);
  end

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      duty_r <= dpsm_pkg::DUTY_RESET;
      wave_r <= 1'b0;
    end else begin
      duty_r <= duty_nxt;
      wave_r <= wave_nxt;
    end
  end

  assign wave = wave_r;

endmodule : dpsm_channel

/* File: dpsm_pin.sv */
`timescale 1ns/10ps
module dpsm_pin (
  input  wire logic core_clk,
  input  wire logic reset,
  input  wire logic wave,
  input  wire logic sel,
  input  wire logic dir_in,
  input  wire logic latch,
  output logic      pin_o,
  output logic      pin_oe
);

  logic o_r;
  logic o_nxt;
  logic oe_r;
  logic oe_nxt;

  // ==========================================================================
  // Pin mux
  // ==========================================================================
  always_comb begin
    oe_nxt = !dir_in;  // Input when direction bit set
    if (sel) begin
      o_nxt = latch & wave;  // Latch gates waveform
    end else begin
      o_nxt = latch;
    end
  end

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      o_r  <= 1'b0;
      oe_r <= 1'b0;
    end else begin
      o_r  <= o_nxt;
      oe_r <= oe_nxt;
    end
  end

  assign pin_o  = o_r;
  assign pin_oe = oe_r;

endmodule : dpsm_pin

/* File: dpsm_top_tb_top.sv */
`timescale 1ns/10ps
module dpsm_top_tb_top;
  // ==========================================================================
  // Bench signals
  // ==========================================================================
  logic        core_clk, reset, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [7:0]  s_axi_awaddr, s_axi_araddr, off;
  logic [7:0]  ph = 8'h00;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [31:0] rng = 32'h0acd;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp, pin_i, pin_o, pin_oe;
  logic        cap0 [256];
  logic        cap1 [256];
  int          fail_count = 0;
  int          checks = 0;

  dpsm_top dpsm_top_inst (
    .core_clk(core_clk), .reset(reset), .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .pin_i(pin_i), .pin_o(pin_o), .pin_oe(pin_oe)
  );

  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  // Free-running capture; off aligns index 0 with the first clock of a full cycle
  always @(posedge core_clk) begin
    ph <= ph + 8'h01;
    cap0[ph] <= pin_o[0];
    cap1[ph] <= pin_o[1];
  end

  // ==========================================================================
  // Helpers
  // ==========================================================================
  function automatic logic [31:0] xs(input logic [31:0] x);
    logic [31:0] y;
    begin
      y = x ^ (x << 13);
      y = y ^ (y >> 17);
      return y ^ (y << 5);
    end
  endfunction : xs

  function automatic logic exp_wave(input logic [7:0] d, input logic four, input int k);
    int len, co, fi;
    begin
      len = four ? 64 : 128;
      co = four ? int'(d[7:2]) : int'(d[7:1]);
      fi = four ? int'(d[1:0]) : int'(d[0]);
      return (k % len) < (co + (((k / len) < fi) ? 1 : 0));
    end
  endfunction : exp_wave

  task automatic final_report;
    if (fail_count == 0 && checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : final_report

  task automatic cmp_word(input logic [31:0] got, input logic [31:0] exp, input string msg);
    checks++;
    if (got !== exp) begin
      fail_count++;
      $display("[FAIL] %0t %s got %h exp %h", $time, msg, got, exp);
    end
  endtask : cmp_word

  task automatic cmp_bit(input logic got, input logic exp, input int k);
    checks++;
    if (got !== exp) begin
      fail_count++;
      $display("[FAIL] %0t pin sample %0d got %b exp %b", $time, k, got, exp);
    end
  endtask : cmp_bit

  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s, input logic [1:0] er);
    logic aw, w, b;
    begin
      @(posedge core_clk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_wstrb <= s;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      aw = 1'b1;
      w = 1'b1;
      b = 1'b1;
      while (b) begin
        @(posedge core_clk);
        if (aw && s_axi_awready === 1'b1) begin
          aw = 1'b0;
          s_axi_awvalid <= 1'b0;
        end
        if (w && s_axi_wready === 1'b1) begin
          w = 1'b0;
          s_axi_wvalid <= 1'b0;
        end
        if (s_axi_bvalid === 1'b1) begin
          b = 1'b0;
          s_axi_bready <= 1'b0;
          cmp_word({30'h0, s_axi_bresp}, {30'h0, er}, "bresp");
        end
      end
    end
  endtask : axi_wr

  task automatic axi_rd(input logic [7:0] a, input logic [31:0] ed, input logic [31:0] m, input logic [1:0] er);
    logic ar;
    begin
      @(posedge core_clk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      ar = 1'b1;
      do begin
        @(posedge core_clk);
        if (ar && s_axi_arready === 1'b1) begin
          ar = 1'b0;
          s_axi_arvalid <= 1'b0;
        end
      end while (s_axi_rvalid !== 1'b1);
      s_axi_rready <= 1'b0;
      cmp_word(s_axi_rdata & m, ed, "rdata");
      cmp_word({30'h0, s_axi_rresp}, {30'h0, er}, "rresp");
    end
  endtask : axi_rd

  // Returns at the edge where the previous full cycle has been fully captured
  task automatic end_cycle;
    do @(posedge core_clk); while (ph != off);
  endtask : end_cycle

  task automatic chk_cycle(input int ch, input logic [7:0] d, input logic four, input logic sel, input logic lat);
    int hi;
    logic e, g;
    logic [7:0] idx;
    begin
      hi = 0;
      for (int k = 0; k < 256; k++) begin
        idx = k[7:0] + off;
        e = sel ? (lat & exp_wave(d, four, k)) : lat;
        g = (ch == 0) ? cap0[idx] : cap1[idx];
        hi += (g === 1'b1) ? 1 : 0;
        cmp_bit(g, e, k);
      end
      cmp_word(32'(hi), sel ? (lat ? {24'h0, d} : 32'h0) : (lat ? 32'h100 : 32'h0), "high count");
    end
  endtask : chk_cycle

  task automatic cfg(input logic [7:0] d0, input logic [7:0] d1, input logic four, input logic [1:0] sel,
                     input logic [1:0] dir, input logic [1:0] lat);
    axi_wr(dpsm_pkg::ADDR_CONTROL, {24'h0, four, sel[1], sel[0], 5'h00}, 4'hf, dpsm_pkg::RESP_OKAY);
    axi_wr(dpsm_pkg::ADDR_DUTY0, {24'h0, d0}, 4'hf, dpsm_pkg::RESP_OKAY);
    axi_wr(dpsm_pkg::ADDR_DUTY1, {24'h0, d1}, 4'hf, dpsm_pkg::RESP_OKAY);
    axi_wr(dpsm_pkg::ADDR_PORT_DIR, {30'h0, dir}, 4'hf, dpsm_pkg::RESP_OKAY);
    axi_wr(dpsm_pkg::ADDR_PORT_OUT, {30'h0, lat}, 4'hf, dpsm_pkg::RESP_OKAY);
  endtask : cfg

  // Two cycle boundaries are skipped: the first cycle may still carry the old settings
  task automatic run(input logic [7:0] d0, input logic [7:0] d1, input logic four, input logic [1:0] sel,
                     input logic [1:0] dir, input logic [1:0] lat);
    cfg(d0, d1, four, sel, dir, lat);
    axi_rd(dpsm_pkg::ADDR_DUTY1, {24'h0, d1}, 32'hffffffff, dpsm_pkg::RESP_OKAY);
    end_cycle();
    end_cycle();
    chk_cycle(0, d0, four, sel[0], lat[0]);
    chk_cycle(1, d1, four, sel[1], lat[1]);
    cmp_word({30'h0, pin_oe}, {30'h0, ~dir}, "pin_oe");
  endtask : run

  // ==========================================================================
  // Main sequence
  // ==========================================================================
  initial begin : main
    logic [7:0] corner [6];
    corner = '{8'h00, 8'hff, 8'h01, 8'h02, 8'h03, 8'h7f};
    reset = 1'b1;
    s_axi_awvalid = 1'b0;
    s_axi_wvalid = 1'b0;
    s_axi_bready = 1'b0;
    s_axi_arvalid = 1'b0;
    s_axi_rready = 1'b0;
    s_axi_awaddr = 8'h00;
    s_axi_araddr = 8'h00;
    s_axi_wdata = 32'h0;
    s_axi_wstrb = 4'h0;
    pin_i = 2'h0;
    off = 8'h00;
    repeat (4) @(posedge core_clk);
    reset <= 1'b0;
    axi_rd(dpsm_pkg::ADDR_CONTROL, 32'h0, 32'hffffffff, dpsm_pkg::RESP_OKAY);
    axi_rd(dpsm_pkg::ADDR_DUTY0, 32'h0, 32'hffffffff, dpsm_pkg::RESP_OKAY);
    axi_rd(dpsm_pkg::ADDR_PORT_DIR, 32'h3, 32'hffffffff, dpsm_pkg::RESP_OKAY);
    axi_rd(dpsm_pkg::ADDR_PORT_OUT, 32'h0, 32'hffffffff, dpsm_pkg::RESP_OKAY);
    axi_rd(8'h18, 32'h0, 32'hffffffff, dpsm_pkg::RESP_SLVERR);
    axi_wr(8'h18, 32'hff, 4'hf, dpsm_pkg::RESP_SLVERR);
    axi_wr(dpsm_pkg::ADDR_DUTY0, 32'h55, 4'he, dpsm_pkg::RESP_OKAY);
    axi_wr(dpsm_pkg::ADDR_STATUS, 32'hfff, 4'hf, dpsm_pkg::RESP_OKAY);
    axi_rd(dpsm_pkg::ADDR_DUTY0, 32'h0, 32'hffffffff, dpsm_pkg::RESP_OKAY);
    // Duty 1 in two-way mode is high only on the first clock of a full cycle
    cfg(8'h01, 8'h00, 1'b0, 2'b11, 2'b00, 2'b11);
    do @(posedge core_clk); while (pin_o[0] !== 1'b1);
    off = ph;
    run(8'h01, 8'h00, 1'b0, 2'b11, 2'b00, 2'b11);
    for (int n = 0; n < 8; n++) begin
      rng = xs(rng);
      run((n < 6) ? corner[n] : rng[7:0], rng[15:8], n[0], 2'b11, 2'b00, 2'b11);
    end
    rng = xs(rng);
    run(rng[7:0], rng[15:8], 1'b1, 2'b01, 2'b00, 2'b01);
    run(rng[23:16], rng[31:24], 1'b0, 2'b11, 2'b00, 2'b10);
    run(rng[15:8], rng[7:0], 1'b1, 2'b00, 2'b00, 2'b01);
    run(rng[7:0], rng[23:16], 1'b0, 2'b11, 2'b11, 2'b11);
    run(8'h40, 8'h40, 1'b1, 2'b11, 2'b00, 2'b11);
    repeat (100) @(posedge core_clk);
    axi_wr(dpsm_pkg::ADDR_DUTY0, 32'hc3, 4'hf, dpsm_pkg::RESP_OKAY);
    end_cycle();
    chk_cycle(0, 8'h40, 1'b1, 1'b1, 1'b1);
    end_cycle();
    chk_cycle(0, 8'hc3, 1'b1, 1'b1, 1'b1);
    for (int n = 0; n < 4; n++) begin
      @(posedge core_clk);
      pin_i <= n[1:0];
      axi_rd(dpsm_pkg::ADDR_STATUS, {20'h0, n[1:0], 10'h0}, 32'h00000c00, dpsm_pkg::RESP_OKAY);
    end
    final_report();
  end

  initial begin : watchdog
    repeat (30000) @(posedge core_clk);
    fail_count++;
    $display("[FAIL] %0t watchdog expired", $time);
    final_report();
  end
endmodule : dpsm_top_tb_top
